// ### rtl/ddl_word_loader.sv
/*
 * serial word loader of a dual 10-bit converter: assembles 16-bit words from
 * the serial pins and moves them into the converter, buffer and control latches.
 * assumes asynchronous serial pins and several system clocks per serial phase.
 */
// Functional notes
// - after chip select falls, shift data in on serial clock falls, msb first
// - after sixteen bits or chip select rise, move the word to its latch
// - targets are channel A, channel B, buffer and control latches
// - reset clears every latch to zero
// - word is four program bits above a twelve-bit data field
// - converter code is data bits 11 to 2; bits 1 and 0 ignored
// - word bit 14 set selects fast mode, clear selects slow mode
// - word bit 13 set selects power-down, clear selects normal operation
// - data field is an unsigned code from 0x000 to 0xfff
// - latches update on the sixteenth rising serial clock edge
// - select bits 15,12: 00 B+buffer, 01 buffer, 10 A and B<-buffer, 11 control
// - control write: data bits 1,0 choose the reference source
// - outputs change on the serial clock rise after the last bit
`timescale 1ns/1ps
`default_nettype none

module ddl_word_loader (
   // system clock and reset
   input  wire logic       CLK_SYS_IN,
   input  wire logic       RST_IN,
   // serial pins from the host
   input  wire logic       CS_N_IN,
   input  wire logic       SCLK_IN,
   input  wire logic       DIN_IN,
   // converter latches
   output var  logic [9:0] CHANNEL_A_OUT,
   output var  logic [9:0] CHANNEL_B_OUT,
   output var  logic [9:0] BUFFER_CODE_OUT,
   // control latch and mode bits
   output var  logic       FAST_MODE_OUT,
   output var  logic       POWERDOWN_OUT,
   output var  logic [1:0] VREF_SEL_OUT,
   output var  logic       VREF_INTERNAL_OUT,
   // one-cycle pulse when a word lands in the latches
   output var  logic       UPDATE_OUT
);

   logic                      cs_n_level;
   logic                      sclk_level;
   logic                      din_level;
   logic                      cs_n_prev;
   logic                      sclk_prev;
   logic                      cs_fall;
   logic                      cs_rise;
   logic                      sclk_fall;
   logic                      sclk_rise;
   logic [ddl_pkg::WORD_W-1:0] shreg;
   logic [ddl_pkg::CNT_W-1:0]  bit_cnt;
   logic                      word_done;
   logic                      pending;
   logic                      commit;
   logic                      shift_en;
   logic [1:0]                tsel;
   logic [9:0]                code;

   // =====================================================================
   // pin synchronisers
   // =====================================================================
   ddl_pin_filter #(.RESET_LEVEL(1'b1)) u_cs_filter (
      .clk_in    (CLK_SYS_IN),
      .rst_in    (RST_IN),
      .pin_in    (CS_N_IN),
      .level_out (cs_n_level)
   );
   ddl_pin_filter #(.RESET_LEVEL(1'b0)) u_sclk_filter (
      .clk_in    (CLK_SYS_IN),
      .rst_in    (RST_IN),
      .pin_in    (SCLK_IN),
      .level_out (sclk_level)
   );
   ddl_pin_filter #(.RESET_LEVEL(1'b0)) u_din_filter (
      .clk_in    (CLK_SYS_IN),
      .rst_in    (RST_IN),
      .pin_in    (DIN_IN),
      .level_out (din_level)
   );

   // =====================================================================
   // edge detection on filtered levels
   // =====================================================================
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         cs_n_prev <= 1'b1;
         sclk_prev <= 1'b0;
      end
      else
      begin
         cs_n_prev <= cs_n_level;
         sclk_prev <= sclk_level;
      end
   end

   // edge strobes; serial edges count only while selected
   assign cs_fall   = cs_n_prev & ~cs_n_level;
   assign cs_rise   = ~cs_n_prev & cs_n_level;
   assign sclk_fall = sclk_prev & ~sclk_level & ~cs_n_level;
   assign sclk_rise = ~sclk_prev & sclk_level & ~cs_n_level;
   assign shift_en  = sclk_fall & ~word_done & ~cs_fall;

   // =====================================================================
   // shift register and bit counter
   // =====================================================================
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
         shreg <= ddl_pkg::WORD_RST;
      else if (cs_fall)
         shreg <= ddl_pkg::WORD_RST;
      else if (shift_en)
         shreg <= {shreg[ddl_pkg::WORD_W-2:0], din_level};
   end

   // count bits; a new selection restarts the word, a full count stops shifting
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
         bit_cnt <= ddl_pkg::CNT_ZERO;
      else if (cs_fall)
         bit_cnt <= ddl_pkg::CNT_ZERO;
      else if (shift_en)
         bit_cnt <= bit_cnt + 5'h01;
   end
   assign word_done = (bit_cnt == ddl_pkg::WORD_BITS);

   // =====================================================================
   // transfer timing
   // =====================================================================
   // a full word waits for the next serial rise or the end of selection
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
         pending <= 1'b0;
      else if (cs_fall || commit)
         pending <= 1'b0;
      else if (shift_en && (bit_cnt + 5'h01) == ddl_pkg::WORD_BITS)
         pending <= 1'b1;
   end

   // full word on serial rise or deselect; partial word on deselect
   assign commit = (pending & (sclk_rise | cs_rise))
                 | (cs_rise & ~word_done & (bit_cnt != ddl_pkg::CNT_ZERO));

   // field decode of the assembled word
   assign tsel = {shreg[ddl_pkg::SEL_HI_POS], shreg[ddl_pkg::SEL_LO_POS]};
   assign code = shreg[ddl_pkg::DATA_MSB:ddl_pkg::CODE_LSB];

   // =====================================================================
   // converter latches
   // =====================================================================
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         CHANNEL_A_OUT   <= ddl_pkg::CODE_RST;
         CHANNEL_B_OUT   <= ddl_pkg::CODE_RST;
         BUFFER_CODE_OUT <= ddl_pkg::CODE_RST;
      end
      else if (commit)
      begin
         case (tsel)
            ddl_pkg::TSEL_B_AND_BUF:
            begin
               CHANNEL_B_OUT   <= code;
               BUFFER_CODE_OUT <= code;
            end
            ddl_pkg::TSEL_BUF_ONLY:
               BUFFER_CODE_OUT <= code;
            ddl_pkg::TSEL_A_LOAD_B:
            begin
               CHANNEL_A_OUT <= code;
               CHANNEL_B_OUT <= BUFFER_CODE_OUT;
            end
            default:
               CHANNEL_A_OUT <= CHANNEL_A_OUT;              // control write
         endcase
      end
   end

   // =====================================================================
   // control latch and mode bits
   // =====================================================================
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         FAST_MODE_OUT     <= 1'b0;
         POWERDOWN_OUT     <= 1'b0;
         VREF_SEL_OUT      <= ddl_pkg::VREF_RST;
         VREF_INTERNAL_OUT <= 1'b0;
      end
      else if (commit)
      begin
         FAST_MODE_OUT <= shreg[ddl_pkg::FAST_POS];
         POWERDOWN_OUT <= shreg[ddl_pkg::PDOWN_POS];
         if (tsel == ddl_pkg::TSEL_CONTROL)
         begin
            VREF_SEL_OUT <= shreg[ddl_pkg::VREF_HI_POS:ddl_pkg::VREF_LO_POS];
            // internal reference exactly when the two select bits differ
            VREF_INTERNAL_OUT <= shreg[ddl_pkg::VREF_HI_POS] ^ shreg[ddl_pkg::VREF_LO_POS];
         end
      end
   end

   // update strobe, rising with the latch write, one cycle after commit
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
   begin
      if (RST_IN)
         UPDATE_OUT <= 1'b0;
      else
         UPDATE_OUT <= commit;
   end

   // =====================================================================
   // assertions
   // =====================================================================
   property p_shift_msb_first;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      shift_en |=> (shreg[0] == $past(din_level)) && (shreg[15:1] == $past(shreg[14:0]));
   endproperty
   a_shift_msb_first: assert property (p_shift_msb_first)
      else $error("serial bit not shifted in msb first");
   property p_restart_on_select;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      cs_fall |=> (bit_cnt == ddl_pkg::CNT_ZERO) && !word_done && !pending
                  && (shreg == ddl_pkg::WORD_RST);
   endproperty
   a_restart_on_select: assert property (p_restart_on_select)
      else $error("chip select fall did not restart the word");
   property p_sixteenth_bit_pends;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (shift_en && bit_cnt == 5'h0f) |=> (pending && word_done);
   endproperty
   a_sixteenth_bit_pends: assert property (p_sixteenth_bit_pends)
      else $error("sixteenth bit did not complete the word");
   property p_rise_commits;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (pending && sclk_rise && !cs_fall) |-> commit ##1 UPDATE_OUT;
   endproperty
   a_rise_commits: assert property (p_rise_commits)
      else $error("complete word not committed on serial clock rise");
   property p_a_load_b;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (commit && tsel == ddl_pkg::TSEL_A_LOAD_B) |=>
         (CHANNEL_A_OUT == $past(code)) && (CHANNEL_B_OUT == $past(BUFFER_CODE_OUT));
   endproperty
   a_a_load_b: assert property (p_a_load_b)
      else $error("channel A write did not move buffer to channel B");
   property p_b_and_buffer;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (commit && tsel == ddl_pkg::TSEL_B_AND_BUF) |=>
         (CHANNEL_B_OUT == $past(code)) && (BUFFER_CODE_OUT == $past(code))
         && $stable(CHANNEL_A_OUT);
   endproperty
   a_b_and_buffer: assert property (p_b_and_buffer)
      else $error("channel B and buffer write wrong");
   property p_control_vref;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (commit && tsel == ddl_pkg::TSEL_CONTROL) |=>
         (VREF_SEL_OUT == $past(shreg[1:0])) && $stable(CHANNEL_A_OUT)
         && $stable(CHANNEL_B_OUT) && $stable(BUFFER_CODE_OUT);
   endproperty
   a_control_vref: assert property (p_control_vref)
      else $error("control write did not set the reference select");
   property p_mode_bits;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      commit |=> (FAST_MODE_OUT == $past(shreg[14])) && (POWERDOWN_OUT == $past(shreg[13]));
   endproperty
   a_mode_bits: assert property (p_mode_bits)
      else $error("speed or power-down not taken from the word");
   property p_no_update_without_commit;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      !commit |=> !UPDATE_OUT && $stable(CHANNEL_A_OUT) && $stable(POWERDOWN_OUT);
   endproperty
   a_no_update_without_commit: assert property (p_no_update_without_commit)
      else $error("latch changed without a committed word");
   property p_reset_clears;
      @(posedge CLK_SYS_IN)
      $fell(RST_IN) |-> (CHANNEL_A_OUT == ddl_pkg::CODE_RST)
         && (CHANNEL_B_OUT == ddl_pkg::CODE_RST) && !FAST_MODE_OUT && !POWERDOWN_OUT;
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("latches not zero after reset");

endmodule : ddl_word_loader

`default_nettype wire

// ### include/ddl_pkg.sv
/*
 * constants for the dual converter serial word loader: word layout,
 * target select codes, reference select codes and reset values.
 * assumes nothing of its surroundings; imported by scoped name only.
 */
`default_nettype none

package ddl_pkg;

   // =====================================================================
   // word layout
   // =====================================================================
   localparam int unsigned WORD_W      = 16;      // bits in one serial word
   localparam int unsigned CNT_W       = 5;       // counter wide enough for 16
   localparam logic [4:0]  WORD_BITS   = 5'h10;   // sixteen bits make a word
   localparam logic [4:0]  CNT_ZERO    = 5'h00;
   localparam int unsigned SEL_HI_POS  = 15;      // target_sel_hi
   localparam int unsigned FAST_POS    = 14;      // fast_mode_bit
   localparam int unsigned PDOWN_POS   = 13;      // powerdown_bit
   localparam int unsigned SEL_LO_POS  = 12;      // target_sel_lo
   localparam int unsigned DATA_MSB    = 11;      // top of the 12-bit data field
   localparam int unsigned CODE_W      = 10;      // converter code width
   localparam int unsigned CODE_LSB    = 2;       // lowest data bit used as code
   localparam int unsigned VREF_HI_POS = 1;       // vref_sel_hi
   localparam int unsigned VREF_LO_POS = 0;       // vref_sel_lo

   // =====================================================================
   // target select codes {target_sel_hi, target_sel_lo}
   // =====================================================================
   localparam logic [1:0] TSEL_B_AND_BUF = 2'h0;  // channel B and buffer
   localparam logic [1:0] TSEL_BUF_ONLY  = 2'h1;  // buffer only
   localparam logic [1:0] TSEL_A_LOAD_B  = 2'h2;  // channel A, B from buffer
   localparam logic [1:0] TSEL_CONTROL   = 2'h3;  // control latch

   // =====================================================================
   // reference select codes {vref_sel_hi, vref_sel_lo}
   // =====================================================================
   localparam logic [1:0] VREF_EXT0     = 2'h0;   // external
   localparam logic [1:0] VREF_INT_1V0  = 2'h1;   // internal 1.024 V
   localparam logic [1:0] VREF_INT_2V0  = 2'h2;   // internal 2.048 V
   localparam logic [1:0] VREF_EXT1     = 2'h3;   // external

   // =====================================================================
   // reset values
   // =====================================================================
   localparam logic [9:0]  CODE_RST  = 10'h000;
   localparam logic [15:0] WORD_RST  = 16'h0000;
   localparam logic [1:0]  VREF_RST  = 2'h0;

endpackage : ddl_pkg

`default_nettype wire

// ### rtl/ddl_pin_filter.sv
/*
 * three-stage pin synchroniser with agreement filter.
 * assumes an asynchronous input and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module ddl_pin_filter #(
   parameter logic RESET_LEVEL = 1'b0
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // pin and filtered level
   input  wire logic pin_in,
   output var  logic level_out
);

   logic stage1;
   logic stage2;
   logic stage3;

   // =====================================================================
   // synchroniser chain; stage1 feeds only stage2
   // =====================================================================
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         stage1 <= RESET_LEVEL;
         stage2 <= RESET_LEVEL;
         stage3 <= RESET_LEVEL;
      end
      else
      begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // level changes only once the last two stages agree
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         level_out <= RESET_LEVEL;
      else if (stage2 == stage3)
         level_out <= stage3;
   end

endmodule : ddl_pin_filter

`default_nettype wire

// ### verification/ddl_host_model.sv
/*
 * host serial port model: drives chip select, serial clock and data.
 * assumes clk_in is the 250 MHz system clock, used only for pacing.
 */
`timescale 1ns/1ps
`default_nettype none

module ddl_host_model (
   // pacing clock
   input  wire logic clk_in,
   // serial pins toward the device
   output var  logic cs_n_out,
   output var  logic sclk_out,
   output var  logic din_out
);
   // =====================================================================
   // serial frames
   // =====================================================================
   localparam int PHASE = 10;    // clocks per serial clock phase, 40 ns

   // idle levels; serial clock rests high outside frames
   initial
   begin
      cs_n_out = 1'b1;
      sclk_out = 1'b1;
      din_out  = 1'b0;
   end

   // wait n clocks, then move just past the edge
   task automatic pace(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : pace

   // one frame of nbits; sel low keeps chip select high throughout
   task automatic send(input logic [15:0] word, input int nbits, input logic sel);
      int i;
      cs_n_out = ~sel;
      pace(PHASE);
      // all nbits bits go out within one chip select assertion
      for (i = 0; i < nbits; i++)
      begin
         din_out = (i < 16) ? word[15 - i] : 1'b1;
         pace(PHASE);
         sclk_out = 1'b0;
         pace(PHASE);
         sclk_out = 1'b1;
      end
      pace(PHASE);
      cs_n_out = 1'b1;
      din_out  = ~din_out;       // released line shows no stale value
      pace(PHASE);
   endtask : send
endmodule : ddl_host_model

`default_nettype wire

// ### verification/tb_top.sv
/*
 * self-checking bench of the serial word loader.
 * assumes the host model paces frames on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   // =====================================================================
   // signals
   // =====================================================================
   logic        clk_sys = 1'b0;
   logic        rst     = 1'b1;
   logic        cs_n;
   logic        sclk;
   logic        din;
   logic [9:0]  chan_a;
   logic [9:0]  chan_b;
   logic [9:0]  buf_code;
   logic        fast;
   logic        pdown;
   logic [1:0]  vref;
   logic        vref_int;
   logic        update;
   logic [9:0]  exp_a;
   logic [9:0]  exp_b;
   logic [9:0]  exp_buf;
   logic        exp_fast;
   logic        exp_pd;
   logic [1:0]  exp_vref;
   logic [15:0] words [0:9];
   int          num_errors = 0;
   int          compares   = 0;
   int          upd_cnt    = 0;
   int          cs_upd     = 0;
   int          cycles     = 0;
   int          k;

   always #2 clk_sys = ~clk_sys;

   ddl_word_loader ddl_word_loader_i (
      .CLK_SYS_IN        (clk_sys),
      .RST_IN            (rst),
      .CS_N_IN           (cs_n),
      .SCLK_IN           (sclk),
      .DIN_IN            (din),
      .CHANNEL_A_OUT     (chan_a),
      .CHANNEL_B_OUT     (chan_b),
      .BUFFER_CODE_OUT   (buf_code),
      .FAST_MODE_OUT     (fast),
      .POWERDOWN_OUT     (pdown),
      .VREF_SEL_OUT      (vref),
      .VREF_INTERNAL_OUT (vref_int),
      .UPDATE_OUT        (update)
   );

   ddl_host_model ddl_host_model_i (
      .clk_in   (clk_sys),
      .cs_n_out (cs_n),
      .sclk_out (sclk),
      .din_out  (din)
   );

   // =====================================================================
   // monitors and timeout
   // =====================================================================
   // count update pulses, note the count when chip select rises
   always @(posedge clk_sys)
   begin
      if (update === 1'b1)
         upd_cnt <= upd_cnt + 1;
   end

   always @(posedge cs_n) cs_upd = upd_cnt;

   // cut a hang short
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         test_done();
      end
   end

   // =====================================================================
   // compare and helper tasks
   // =====================================================================
   task automatic check_code(input string name, input logic [9:0] e, input logic [9:0] g);
      compares++;
      if (e !== g)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask : check_code

   task automatic check_mode(input string name, input logic [1:0] e, input logic [1:0] g);
      compares++;
      if (e !== g)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, e, g);
      end
   endtask : check_mode

   // expected effect of one committed word
   task automatic apply(input logic [15:0] w);
      logic [9:0] code;
      logic [1:0] sel;
      code = w[ddl_pkg::DATA_MSB:ddl_pkg::CODE_LSB];
      sel  = {w[ddl_pkg::SEL_HI_POS], w[ddl_pkg::SEL_LO_POS]};
      exp_fast = w[ddl_pkg::FAST_POS];
      exp_pd   = w[ddl_pkg::PDOWN_POS];
      if (sel == ddl_pkg::TSEL_A_LOAD_B) exp_b = exp_buf;
      if (sel == ddl_pkg::TSEL_A_LOAD_B) exp_a = code;
      if (sel == ddl_pkg::TSEL_B_AND_BUF) exp_b = code;
      if (sel[1] == 1'b0) exp_buf = code;
      if (sel == ddl_pkg::TSEL_CONTROL) exp_vref = w[1:0];
   endtask : apply

   task automatic check_all();
      check_code("channel a", exp_a, chan_a);
      check_code("channel b", exp_b, chan_b);
      check_code("buffer", exp_buf, buf_code);
      check_mode("fast", {1'b0, exp_fast}, {1'b0, fast});
      check_mode("pdown", {1'b0, exp_pd}, {1'b0, pdown});
      check_mode("vref", exp_vref, vref);
      check_mode("vref int", {1'b0, ^exp_vref}, {1'b0, vref_int});
   endtask : check_all

   // one frame, with the moment of the commit checked
   task automatic frame(input logic [15:0] w, input int nbits);
      int base;
      base = upd_cnt;
      ddl_host_model_i.send(w, nbits, 1'b1);
      check_mode("upd at cs rise", (nbits >= 16) ? 2'h1 : 2'h0, 2'(cs_upd - base));
      check_mode("upd per frame", 2'h1, 2'(upd_cnt - base));
      apply((nbits >= 16) ? w : (w >> (16 - nbits)));
      check_all();
   endtask : frame

   task automatic do_reset();
      rst = 1'b1;
      repeat (10) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      {exp_a, exp_b, exp_buf, exp_fast, exp_pd, exp_vref} = '0;
      ddl_host_model_i.pace(10);
      check_all();
   endtask : do_reset

   task automatic test_done();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   // =====================================================================
   // main sequence
   // =====================================================================
   initial
   begin
      words = '{16'hd002, 16'h9001, 16'hf003, 16'h9000, 16'h4abf,
                16'h1ffc, 16'ha001, 16'h8803, 16'h0fff, 16'h8000};
      do_reset();
      // every select and reference code, modes from each word
      for (k = 0; k < 10; k++)
         frame(words[k], 16);
      // bits past the sixteenth are ignored
      frame(16'h2555, 18);
      // partial word committed on chip select rise, then a clean word
      frame(16'hd000, 4);
      frame(16'h4004, 16);
      // serial clock with chip select high changes nothing
      k = upd_cnt;
      ddl_host_model_i.send(16'hffff, 16, 1'b0);
      check_mode("idle upd", 2'h0, 2'(upd_cnt - k));
      check_all();
      // second reset in mid-run, then traffic again
      do_reset();
      frame(16'ha7f8, 16);
      test_done();
   end
endmodule : tb_top

`default_nettype wire
